// ---- hw/clkmon_pkg.sv ----
// Purpose: shared constants for the reference clock and loop monitor
// Assumes: one 10 MHz clock domain, AHB-Lite register access
// Notes: offsets are byte addresses of 32-bit words
package clkmon_pkg;

  localparam int NUM_REF = 4;
  localparam int NUM_LOOP = 3;
  localparam int CNT_W = 24;
  localparam int ERR_W = 8;
  localparam int TW_W = 32;
  localparam int ACC_W = 56;
  localparam int NUM_SRC = 15;
  localparam int ADDR_W = 8;
  localparam int EXP_W = 5;

  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_NOMINAL = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_WINDOW = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_JITTER = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_VALID_TIME = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_LOCK_THR = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_HIST_CTRL = 8'h18;
  localparam logic [ADDR_W-1:0] ADDR_FREE_RUN = 8'h1c;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h20;
  localparam logic [ADDR_W-1:0] ADDR_STICKY = 8'h24;
  localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h28;
  localparam logic [ADDR_W-1:0] ADDR_INTERRUPT_CLEAR_FIELD = 8'h2c;

  // control register fields
  localparam int CTRL_LATE_LSB = 0;
  localparam int CTRL_EARLY_LSB = 4;
  localparam int CTRL_PPS_LSB = 8;
  localparam int CTRL_INT_EN = 12;
  localparam int CTRL_INT_POL = 13;
  localparam int CTRL_INT_AND = 14;
  localparam int CTRL_INT_PIN = 15;
  localparam int CTRL_APLL3_SEL = 16;
  localparam int CTRL_W = 17;
  localparam int HIST_EXP_LSB = 8;
  localparam logic [EXP_W-1:0] HIST_EXP_MAX = 5'h17;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 17'h0_0000;
  localparam logic [CNT_W-1:0] NOMINAL_RST = 24'h00_2710;
  localparam logic [15:0] LATE_RST = 16'h01f4;
  localparam logic [15:0] EARLY_RST = 16'h01f4;
  localparam logic [CNT_W-1:0] JITTER_RST = 24'h00_03e8;
  localparam logic [CNT_W-1:0] VALID_TIME_RST = 24'h00_0400;
  localparam logic [31:0] LOCK_THR_RST = 32'h4020_1008;
  localparam logic [EXP_W-1:0] HIST_EXP_RST = 5'h0a;
  localparam logic [NUM_SRC-1:0] MASK_RST = 15'h7fff;

  // interrupt source layout, low to high:
  // xo loss, ref loss x3, analog unlock x2, loop lock loss x3,
  // holdover x3, switchover x3
  localparam int SRC_HOLD_LSB = 9;

  typedef enum logic [1:0] {
    MODE_FREERUN,
    MODE_LOCKED,
    MODE_HOLDOVER
  } loop_mode_t;

endpackage

// ---- hw/clock_monitor.sv ----
// Purpose: reference window/pps monitors, lock detectors, tuning word
//   history and sticky interrupt logic behind an AHB-Lite slave
// Assumes: loop-side inputs share hclk; ref_in pins are asynchronous
// Notes: zero wait state slave, always OKAY
//
// Operation
// - A pulse before nominal plus late threshold is valid, clears missing flag.
// - No pulse by the late limit sets the missing-pulse flag.
// - One window counter per input; flags ORed to pin and status bit.
// - Pulse before nominal minus early threshold sets runt flag; later clears.
// - Early check works only while the late check is enabled.
// - Pps flag clears on pulse within window, sets when window expires.
// - Lock status for three analog and three digital loops.
// - Third analog check selected: third digital loop checks phase only.
// - Digital frequency unlock flag uses lock/unlock hysteresis.
// - Third analog loop frequency check uses same hysteresis.
// - Phase unlock flag clears below lock, sets above unlock threshold.
// - Tuning word: filter when locked, history in holdover, free-run word.
// - Accumulate filter output per period while locked; store on failure.
// - On failure drop running sum and newest average.
// - Reset clears history; two periods must expire before storing.
// - History survives switchover; cleared only by reset or by toggling enable.
// - Holdover without history uses the free-run tuning word.
// - Sticky flag set on rising or falling live edge per polarity.
// - Per-flag mask; AND or OR combine to either status pin.
// - Writing one to clear field clears interrupt; field reads zero.
// - Sources: xo loss, ref loss, analog and digital unlock, events.
// - Input qualified after monitors stay clear for validation time.
// - Disabled monitor never flags and is ignored for qualification.
`timescale 1ns/1ps
`default_nettype none
module clock_monitor
  (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [clkmon_pkg::NUM_REF-1:0] ref_in,
  input wire logic xo_loss_in,
  input wire logic [1:0] apll_unlock_in,
  input wire logic [clkmon_pkg::ERR_W-1:0] apll3_freq_err,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0] dpll_enable,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][clkmon_pkg::ERR_W-1:0]
    dpll_freq_err,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][clkmon_pkg::ERR_W-1:0]
    dpll_phase_err,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][1:0] dpll_mode,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0] ref_valid,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0] switchover_evt,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][clkmon_pkg::TW_W-1:0]
    loop_filter_word,
  output logic [clkmon_pkg::NUM_LOOP-1:0][clkmon_pkg::TW_W-1:0]
    tuning_word,
  output logic [clkmon_pkg::NUM_REF-1:0] ref_qualified,
  output logic [clkmon_pkg::NUM_LOOP-1:0] loss_of_lock_flag,
  output logic status_pin_a,
  output logic status_pin_b
  );
  import clkmon_pkg::*;

  typedef struct packed {
    logic [NUM_REF-1:0] sync1;
    logic [NUM_REF-1:0] sync2;
    logic [NUM_REF-1:0] sync3;
    logic [NUM_REF-1:0][CNT_W-1:0] cnt;
    logic [NUM_REF-1:0] miss;
    logic [NUM_REF-1:0] runt;
    logic [NUM_REF-1:0] pps;
    logic [NUM_REF-1:0][CNT_W-1:0] qtimer;
    logic [NUM_REF-1:0] qual;
    logic [CTRL_W-1:0] ctrl;
    logic [CNT_W-1:0] nominal;
    logic [15:0] late;
    logic [15:0] early;
    logic [CNT_W-1:0] pps_jitter_threshold;
    logic [CNT_W-1:0] valid_time;
    logic [31:0] lock_thr;
    logic [NUM_LOOP-1:0] history_enable_bit;
    logic [EXP_W-1:0] history_period_setting;
    logic [TW_W-1:0] free_run_tuning_word;
    logic [NUM_SRC-1:0] mask;
    logic [NUM_LOOP-1:0] frequency_unlock_flag;
    logic [NUM_LOOP-1:0] phase_unlock_flag;
    logic apll3_unlock;
    logic [NUM_LOOP-1:0][ACC_W-1:0] acc;
    logic [NUM_LOOP-1:0][CNT_W-1:0] htimer;
    logic [NUM_LOOP-1:0][1:0] nav;
    logic [NUM_LOOP-1:0][TW_W-1:0] last_avg;
    logic [NUM_LOOP-1:0][TW_W-1:0] prev_avg;
    logic [NUM_LOOP-1:0][TW_W-1:0] hist_word;
    logic [NUM_LOOP-1:0] hist_valid;
    logic [NUM_LOOP-1:0] ref_valid_d;
    logic [NUM_LOOP-1:0][TW_W-1:0] tw;
    logic [NUM_LOOP-1:0] lock_lost;
    logic [NUM_SRC-1:0] live_d;
    logic [NUM_SRC-1:0] sticky;
    logic irq;
    logic pin_a;
    logic pin_b;
    logic wr_pend;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } state_t;

  state_t s_r;
  state_t s_nxt;

  logic [NUM_REF-1:0] edge_seen;
  logic [CNT_W:0] late_lim;
  logic [CNT_W:0] pps_lim;
  logic [CNT_W-1:0] early_lim;
  logic [NUM_REF-1:0] late_en;
  logic [NUM_REF-1:0] early_en;
  logic [NUM_REF-1:0] pps_en;
  logic [EXP_W-1:0] hexp;
  logic [CNT_W-1:0] period_end;
  logic [ACC_W-1:0] avg;
  logic [NUM_SRC-1:0] live;
  logic [NUM_SRC-1:0] rise;
  logic [NUM_SRC-1:0] fall;
  logic [NUM_SRC-1:0] set_flags;
  logic [NUM_SRC-1:0] unmasked;
  logic [NUM_LOOP-1:0] in_holdover;
  logic addr_ok;
  logic interrupt_clear_field;
  logic win_any;
  logic irq_next;
  loop_mode_t mode;

  // clears below lock, sets above unlock, holds in between
  function automatic logic hysteresis(input logic flag,
                                      input logic [ERR_W-1:0] err,
                                      input logic [ERR_W-1:0] lock_thr,
                                      input logic [ERR_W-1:0] unlock_thr);
    logic res;
    res = flag;
    if (err < lock_thr)
      res = 1'b0;
    else if (err > unlock_thr)
      res = 1'b1;
    return res;
  endfunction

  function automatic logic [CNT_W:0] widen_sum(input logic [CNT_W-1:0] a,
                                               input logic [CNT_W-1:0] b);
    return {1'b0, a} + {1'b0, b};
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    edge_seen = '0;
    mode = MODE_FREERUN;
    avg = '0;
    late_en = s_r.ctrl[CTRL_LATE_LSB +: NUM_REF];
    early_en = s_r.ctrl[CTRL_EARLY_LSB +: NUM_REF] & late_en;
    pps_en = s_r.ctrl[CTRL_PPS_LSB +: NUM_REF];
    late_lim = widen_sum(s_r.nominal, {8'h00, s_r.late});
    pps_lim = widen_sum(s_r.nominal, s_r.pps_jitter_threshold);
    early_lim = (s_r.nominal > {8'h00, s_r.early}) ?
                s_r.nominal - {8'h00, s_r.early} : '0;
    hexp = (s_r.history_period_setting > HIST_EXP_MAX) ?
           HIST_EXP_MAX : s_r.history_period_setting;
    period_end = (CNT_W'(1) << hexp) - CNT_W'(1);

    // only sync2 onward is looked at by logic
    s_nxt.sync1 = ref_in;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.sync3 = s_r.sync2;
    edge_seen = s_r.sync2 & ~s_r.sync3;

    for (int i = 0; i < NUM_REF; i++)
    begin
      if (edge_seen[i])
      begin
        s_nxt.cnt[i] = '0;
        s_nxt.miss[i] = 1'b0;
        s_nxt.runt[i] = early_en[i] && (s_r.cnt[i] < early_lim);
        s_nxt.pps[i] = 1'b0;
      end
      else
      begin
        if (s_r.cnt[i] != '1)
          s_nxt.cnt[i] = s_r.cnt[i] + CNT_W'(1);
        if ({1'b0, s_r.cnt[i]} >= late_lim)
          s_nxt.miss[i] = 1'b1;
        if ({1'b0, s_r.cnt[i]} >= pps_lim)
          s_nxt.pps[i] = 1'b1;
      end
      // a disabled monitor is held clear and so never blocks qualifying
      if (!late_en[i])
        s_nxt.miss[i] = 1'b0;
      if (!early_en[i])
        s_nxt.runt[i] = 1'b0;
      if (!pps_en[i])
        s_nxt.pps[i] = 1'b0;
      if (s_r.miss[i] || s_r.runt[i] || s_r.pps[i])
      begin
        s_nxt.qtimer[i] = '0;
        s_nxt.qual[i] = 1'b0;
      end
      else if (s_r.qtimer[i] >= s_r.valid_time)
        s_nxt.qual[i] = 1'b1;
      else
        s_nxt.qtimer[i] = s_r.qtimer[i] + CNT_W'(1);
    end
    win_any = |(s_r.miss | s_r.runt);

    // lock detectors
    for (int i = 0; i < NUM_LOOP; i++)
    begin
      s_nxt.frequency_unlock_flag[i] =
        hysteresis(s_r.frequency_unlock_flag[i], dpll_freq_err[i],
                   s_r.lock_thr[7:0], s_r.lock_thr[15:8]);
      s_nxt.phase_unlock_flag[i] =
        hysteresis(s_r.phase_unlock_flag[i], dpll_phase_err[i],
                   s_r.lock_thr[23:16], s_r.lock_thr[31:24]);
    end
    if (s_r.ctrl[CTRL_APLL3_SEL])
    begin
      s_nxt.frequency_unlock_flag[NUM_LOOP-1] = 1'b0;
      // digital check of the third analog loop needs its digital loop
      if (dpll_enable[NUM_LOOP-1])
        s_nxt.apll3_unlock =
          hysteresis(s_r.apll3_unlock, apll3_freq_err,
                     s_r.lock_thr[7:0], s_r.lock_thr[15:8]);
    end
    else
      s_nxt.apll3_unlock = 1'b0;
    s_nxt.lock_lost = s_r.frequency_unlock_flag |
                      s_r.phase_unlock_flag;

    // tuning word history
    for (int i = 0; i < NUM_LOOP; i++)
    begin
      mode = loop_mode_t'(dpll_mode[i]);
      avg = (s_r.acc[i] + ACC_W'(loop_filter_word[i])) >> hexp;
      s_nxt.ref_valid_d[i] = ref_valid[i];
      if (!s_r.history_enable_bit[i])
      begin
        s_nxt.acc[i] = '0;
        s_nxt.htimer[i] = '0;
        s_nxt.nav[i] = 2'h0;
        s_nxt.hist_valid[i] = 1'b0;
        s_nxt.hist_word[i] = '0;
      end
      else if (s_r.ref_valid_d[i] && !ref_valid[i])
      begin
        // the newest average may hold corrupt words, take the one before
        if (s_r.nav[i] == 2'h2)
        begin
          s_nxt.hist_word[i] = s_r.prev_avg[i];
          s_nxt.hist_valid[i] = 1'b1;
        end
        s_nxt.acc[i] = '0;
        s_nxt.htimer[i] = '0;
        s_nxt.nav[i] = 2'h0;
      end
      else if (mode == MODE_LOCKED && ref_valid[i])
      begin
        if (s_r.htimer[i] == period_end)
        begin
          s_nxt.prev_avg[i] = s_r.last_avg[i];
          s_nxt.last_avg[i] = avg[TW_W-1:0];
          s_nxt.nav[i] = (s_r.nav[i] == 2'h2) ? 2'h2 : s_r.nav[i] + 2'h1;
          s_nxt.acc[i] = '0;
          s_nxt.htimer[i] = '0;
        end
        else
        begin
          s_nxt.acc[i] = s_r.acc[i] + ACC_W'(loop_filter_word[i]);
          s_nxt.htimer[i] = s_r.htimer[i] + CNT_W'(1);
        end
      end
      else
      begin
        // stored word is kept across switchover and holdover exit
        s_nxt.acc[i] = '0;
        s_nxt.htimer[i] = '0;
        s_nxt.nav[i] = 2'h0;
      end
      unique case (mode)
        MODE_LOCKED:
          s_nxt.tw[i] = loop_filter_word[i];
        MODE_HOLDOVER:
          s_nxt.tw[i] = s_r.hist_valid[i] ? s_r.hist_word[i]
                        : s_r.free_run_tuning_word;
        default:
          s_nxt.tw[i] = s_r.free_run_tuning_word;
      endcase
    end

    // interrupt
    for (int i = 0; i < NUM_LOOP; i++)
      in_holdover[i] = (loop_mode_t'(dpll_mode[i]) == MODE_HOLDOVER);
    live = {switchover_evt, in_holdover, s_r.lock_lost, apll_unlock_in,
            ~ref_valid, xo_loss_in};
    s_nxt.live_d = live;
    rise = live & ~s_r.live_d;
    fall = ~live & s_r.live_d;
    set_flags = s_r.ctrl[CTRL_INT_POL] ? rise : fall;
    if (!s_r.ctrl[CTRL_INT_EN])
      set_flags = '0;
    interrupt_clear_field = s_r.wr_pend && (s_r.wr_addr == ADDR_INTERRUPT_CLEAR_FIELD) && hwdata[0];
    // a new edge in the clearing cycle still lands
    s_nxt.sticky = (interrupt_clear_field ? '0 : s_r.sticky) | set_flags;
    unmasked = s_nxt.sticky & ~s_r.mask;
    if (s_r.ctrl[CTRL_INT_AND])
      irq_next = (|unmasked) && (&(s_nxt.sticky | s_r.mask));
    else
      irq_next = |unmasked;
    irq_next = irq_next && s_r.ctrl[CTRL_INT_EN];
    s_nxt.irq = irq_next;
    s_nxt.pin_a = s_r.ctrl[CTRL_INT_PIN] ? win_any : irq_next;
    s_nxt.pin_b = s_r.ctrl[CTRL_INT_PIN] ? irq_next : win_any;

    // register writes in the data phase
    if (s_r.wr_pend)
    begin
      unique case (s_r.wr_addr)
        ADDR_CTRL:
          s_nxt.ctrl = hwdata[CTRL_W-1:0];
        ADDR_NOMINAL:
          s_nxt.nominal = hwdata[CNT_W-1:0];
        ADDR_WINDOW:
        begin
          s_nxt.late = hwdata[15:0];
          s_nxt.early = hwdata[31:16];
        end
        ADDR_JITTER:
          s_nxt.pps_jitter_threshold = hwdata[CNT_W-1:0];
        ADDR_VALID_TIME:
          s_nxt.valid_time = hwdata[CNT_W-1:0];
        ADDR_LOCK_THR:
          s_nxt.lock_thr = hwdata;
        ADDR_HIST_CTRL:
        begin
          s_nxt.history_enable_bit = hwdata[NUM_LOOP-1:0];
          s_nxt.history_period_setting = hwdata[HIST_EXP_LSB +: EXP_W];
        end
        ADDR_FREE_RUN:
          s_nxt.free_run_tuning_word = hwdata;
        ADDR_MASK:
          s_nxt.mask = hwdata[NUM_SRC-1:0];
        default:
          s_nxt.mask = s_r.mask;
      endcase
    end

    // address phase
    addr_ok = hsel && htrans[1] && hready;
    s_nxt.wr_pend = addr_ok && hwrite;
    s_nxt.wr_addr = haddr[ADDR_W-1:0];
    s_nxt.ready = 1'b1;
    s_nxt.resp = 1'b0;
    s_nxt.rdata = '0;
    if (addr_ok && !hwrite)
    begin
      unique case (haddr[ADDR_W-1:0])
        ADDR_CTRL:
          s_nxt.rdata = 32'(s_r.ctrl);
        ADDR_NOMINAL:
          s_nxt.rdata = 32'(s_r.nominal);
        ADDR_WINDOW:
          s_nxt.rdata = {s_r.early, s_r.late};
        ADDR_JITTER:
          s_nxt.rdata = 32'(s_r.pps_jitter_threshold);
        ADDR_VALID_TIME:
          s_nxt.rdata = 32'(s_r.valid_time);
        ADDR_LOCK_THR:
          s_nxt.rdata = s_r.lock_thr;
        ADDR_HIST_CTRL:
          s_nxt.rdata = 32'({s_r.history_period_setting, 5'h00,
                             s_r.history_enable_bit});
        ADDR_FREE_RUN:
          s_nxt.rdata = s_r.free_run_tuning_word;
        ADDR_STATUS:
          s_nxt.rdata = 32'({s_r.hist_valid, s_r.irq, s_r.apll3_unlock,
                             s_r.phase_unlock_flag,
                             s_r.frequency_unlock_flag, s_r.qual,
                             s_r.pps, s_r.miss | s_r.runt});
        ADDR_STICKY:
          s_nxt.rdata = 32'(s_r.sticky);
        ADDR_MASK:
          s_nxt.rdata = 32'(s_r.mask);
        default:
          s_nxt.rdata = '0; // clear field self-clears, reads zero
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RST;
      s_r.nominal <= NOMINAL_RST;
      s_r.late <= LATE_RST;
      s_r.early <= EARLY_RST;
      s_r.pps_jitter_threshold <= JITTER_RST;
      s_r.valid_time <= VALID_TIME_RST;
      s_r.lock_thr <= LOCK_THR_RST;
      s_r.history_period_setting <= HIST_EXP_RST;
      s_r.mask <= MASK_RST;
      s_r.ready <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end

  assign hreadyout = s_r.ready;
  assign hrdata = s_r.rdata;
  assign hresp = s_r.resp;
  assign tuning_word = s_r.tw;
  assign ref_qualified = s_r.qual;
  assign loss_of_lock_flag = s_r.lock_lost;
  assign status_pin_a = s_r.pin_a;
  assign status_pin_b = s_r.pin_b;

endmodule
`default_nettype wire

// ---- verification/clock_monitor_bench.sv ----
// Purpose: self-checking bench for the clock monitor
// Assumes: zero wait state slave, lock thresholds left at reset
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module clock_monitor_bench;
  import clkmon_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, xo_loss_in;
  logic status_pin_a, status_pin_b;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, apll_unlock_in;
  logic [ERR_W-1:0] apll3_freq_err;
  logic [NUM_LOOP-1:0] dpll_enable, ref_valid, switchover_evt, loss_of_lock_flag;
  logic [NUM_LOOP-1:0][ERR_W-1:0] dpll_freq_err, dpll_phase_err;
  logic [NUM_LOOP-1:0][1:0] dpll_mode;
  logic [NUM_LOOP-1:0][TW_W-1:0] loop_filter_word, tuning_word;
  logic [NUM_REF-1:0] ref_in, ref_qualified;
  logic [3:0][15:0] period;
  int err_count, check_count;
  clock_monitor clock_monitor_inst (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ref_in(ref_in),
    .xo_loss_in(xo_loss_in), .apll_unlock_in(apll_unlock_in),
    .apll3_freq_err(apll3_freq_err), .dpll_enable(dpll_enable),
    .dpll_freq_err(dpll_freq_err), .dpll_phase_err(dpll_phase_err),
    .dpll_mode(dpll_mode), .ref_valid(ref_valid),
    .switchover_evt(switchover_evt), .loop_filter_word(loop_filter_word),
    .tuning_word(tuning_word), .ref_qualified(ref_qualified),
    .loss_of_lock_flag(loss_of_lock_flag), .status_pin_a(status_pin_a),
    .status_pin_b(status_pin_b));
  // periods set by the bench, including ones outside the window monitors' range
  ref_source_model ref_source_model_inst (.clk(hclk), .period(period),
    .pulse(ref_in));
  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic chk(input string nm, input logic [31:0] got,
    input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic t_reset;
    logic [7:0] a [12] = '{ADDR_CTRL, ADDR_NOMINAL, ADDR_WINDOW, ADDR_JITTER,
      ADDR_VALID_TIME, ADDR_LOCK_THR, ADDR_HIST_CTRL, ADDR_MASK, ADDR_FREE_RUN,
      ADDR_STICKY, ADDR_INTERRUPT_CLEAR_FIELD, 8'h40};
    logic [31:0] e [12] = '{32'h0, 32'h2710, 32'h01f4_01f4, 32'h3e8, 32'h400,
      32'h4020_1008, 32'h0a00, 32'h7fff, 32'h0, 32'h0, 32'h0, 32'h0};
    bus(1'b1, 8'h40, 32'hffff_ffff);
    for (int i = 0; i < 12; i++)
    begin
      bus(1'b0, a[i], 32'h0);
      chk("reset value", rd, e[i]);
    end
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("history at reset", rd[22:20], 32'h0);
    $display("test reset done");
  endtask
  task automatic t_window;
    bus(1'b1, ADDR_NOMINAL, 32'd100);
    bus(1'b1, ADDR_WINDOW, 32'h000a_000a);
    bus(1'b1, ADDR_JITTER, 32'd20);
    bus(1'b1, ADDR_VALID_TIME, 32'd200);
    bus(1'b1, ADDR_CTRL, 32'h0411); // early only together with late
    period <= {16'd0, 16'd100, 16'd0, 16'd100};
    cyc(700);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status ok", rd[11:0], 32'hf00);
    chk("window pin", status_pin_b, 32'h0);
    period <= {16'd0, 16'd0, 16'd0, 16'd0};
    cyc(300);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("lost", {rd[6], rd[0], status_pin_b, ref_qualified[0]}, 32'he);
    period[0] <= 16'd50;
    cyc(200);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("runt", rd[0], 32'h1);
    period <= {16'd0, 16'd100, 16'd0, 16'd100};
    cyc(260);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("recovered", {rd[6], rd[0]}, 32'h0);
    cyc(300);
    chk("requalified", ref_qualified[0], 32'h1);
    $display("test window done");
  endtask
  task automatic t_lock;
    logic [7:0] f [6] = '{8'd20, 8'd12, 8'd4, 8'd0, 8'd0, 8'd0};
    logic [7:0] p [6] = '{8'd0, 8'd0, 8'd0, 8'd70, 8'd40, 8'd10};
    logic e [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++)
    begin
      dpll_freq_err[0] <= f[i];
      dpll_phase_err[0] <= p[i];
      cyc(5);
      chk("loop lock", loss_of_lock_flag[0], e[i]);
    end
    bus(1'b1, ADDR_CTRL, 32'h1_0411); // third loop kept enabled
    apll3_freq_err <= 8'd20;
    dpll_freq_err[2] <= 8'd20;
    cyc(5);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("analog3 unlock", {rd[18], rd[14]}, 32'h2);
    apll3_freq_err <= 8'd4;
    dpll_freq_err[2] <= 8'd0;
    cyc(5);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("analog3 lock", rd[18], 32'h0);
    $display("test lock done");
  endtask
  task automatic t_tune;
    bus(1'b1, ADDR_FREE_RUN, 32'h1234_5678);
    dpll_mode[1] <= 2'h2;
    cyc(3);
    chk("holdover no hist", tuning_word[1], 32'h1234_5678);
    dpll_mode[1] <= 2'h0;
    cyc(3);
    chk("free run", tuning_word[1], 32'h1234_5678);
    loop_filter_word[1] <= 32'haaaa_0001;
    dpll_mode[1] <= 2'h1;
    cyc(3);
    chk("locked", tuning_word[1], 32'haaaa_0001);
    $display("test tune done");
  endtask
  task automatic t_hist;
    bus(1'b1, ADDR_HIST_CTRL, 32'h0401);
    loop_filter_word[0] <= 32'h0100_0040;
    dpll_mode[0] <= 2'h1;
    cyc(100);
    // newest words must not leak into the stored average
    loop_filter_word[0] <= 32'h0f00_0000;
    cyc(20);
    ref_valid[0] <= 1'b0;
    cyc(2);
    dpll_mode[0] <= 2'h2;
    cyc(3);
    chk("holdover word", tuning_word[0], 32'h0100_0040);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("history kept", rd[20], 32'h1);
    bus(1'b1, ADDR_HIST_CTRL, 32'h0400);
    bus(1'b1, ADDR_HIST_CTRL, 32'h0401);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("history wiped", rd[20], 32'h0);
    cyc(3);
    chk("fallback word", tuning_word[0], 32'h1234_5678);
    ref_valid[0] <= 1'b1;
    dpll_mode[0] <= 2'h0;
    $display("test history done");
  endtask
  task automatic t_irq;
    bus(1'b1, ADDR_MASK, 32'h7ffe);
    bus(1'b1, ADDR_CTRL, 32'h3411);
    bus(1'b1, ADDR_INTERRUPT_CLEAR_FIELD, 32'h1);
    cyc(2);
    chk("irq idle", status_pin_a, 32'h0);
    xo_loss_in <= 1'b1;
    cyc(3);
    bus(1'b0, ADDR_STICKY, 32'h0);
    chk("xo sticky", {rd[0], status_pin_a}, 32'h3);
    xo_loss_in <= 1'b0;
    cyc(3);
    chk("irq held", status_pin_a, 32'h1);
    bus(1'b1, ADDR_INTERRUPT_CLEAR_FIELD, 32'h1);
    cyc(2);
    bus(1'b0, ADDR_STICKY, 32'h0);
    chk("cleared", {rd[14:0], status_pin_a}, 32'h0);
    apll_unlock_in[0] <= 1'b1;
    cyc(3);
    bus(1'b0, ADDR_STICKY, 32'h0);
    chk("masked", {rd[4], status_pin_a}, 32'h2);
    bus(1'b1, ADDR_MASK, 32'h7fee);
    bus(1'b1, ADDR_CTRL, 32'hd411);
    bus(1'b1, ADDR_INTERRUPT_CLEAR_FIELD, 32'h1);
    xo_loss_in <= 1'b1;
    cyc(2);
    xo_loss_in <= 1'b0;
    cyc(3);
    chk("and one", status_pin_b, 32'h0);
    apll_unlock_in[0] <= 1'b0;
    cyc(3);
    chk("and both", status_pin_b, 32'h1);
    $display("test interrupt done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    {hsel, hwrite, xo_loss_in, apll_unlock_in, htrans} = '0;
    {haddr, hwdata, apll3_freq_err, switchover_evt, dpll_mode} = '0;
    {dpll_freq_err, dpll_phase_err, loop_filter_word, period} = '0;
    dpll_enable = 3'h7;
    ref_valid = 3'h7;
    hresetn = 1'b0;
    cyc(6);
    hresetn <= 1'b1;
    t_reset;
    t_window;
    t_lock;
    t_tune;
    t_hist;
    t_irq;
    conclude;
  end
  initial
  begin
    cyc(20000);
    err_count++;
    $display("mismatch watchdog expected done seen timeout");
    conclude;
  end
endmodule
`default_nettype wire

// ---- verification/clock_monitor_sva.sv ----
// Purpose: bus, tuning word and loop lock checks at the monitor's ports
// Assumes: lock thresholds keep their reset values throughout the run
// Notes: loop 0 is the one the thresholds are judged on
`timescale 1ns/1ps
`default_nettype none
module clock_monitor_sva
  (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic hresp,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][clkmon_pkg::ERR_W-1:0]
    dpll_freq_err,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][clkmon_pkg::ERR_W-1:0]
    dpll_phase_err,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][1:0] dpll_mode,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][clkmon_pkg::TW_W-1:0]
    loop_filter_word,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0][clkmon_pkg::TW_W-1:0]
    tuning_word,
  input wire logic [clkmon_pkg::NUM_LOOP-1:0] loss_of_lock_flag
  );
  import clkmon_pkg::*;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  localparam logic [7:0] FL = LOCK_THR_RST[7:0];
  localparam logic [7:0] FU = LOCK_THR_RST[15:8];
  localparam logic [7:0] PL = LOCK_THR_RST[23:16];
  localparam logic [7:0] PU = LOCK_THR_RST[31:24];
  logic [7:0] f0;
  logic [7:0] p0;
  assign f0 = dpll_freq_err[0];
  assign p0 = dpll_phase_err[0];
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_idle: assert property
    (!(hsel && htrans[1] && hready && !hwrite) |=> hrdata == 32'h0)
    else $error("hrdata not zero outside read");
  a_tw_locked: assert property
    (dpll_mode[0] == 2'h1 |=> tuning_word[0] == $past(loop_filter_word[0]))
    else $error("locked tuning word wrong");
  a_freq_unlock: assert property ((f0 > FU)[*3] |-> loss_of_lock_flag[0])
    else $error("freq unlock not flagged");
  a_phase_unlock: assert property ((p0 > PU)[*3] |-> loss_of_lock_flag[0])
    else $error("phase unlock not flagged");
  a_lock_clear: assert property
    ((f0 < FL && p0 < PL)[*3] |-> !loss_of_lock_flag[0])
    else $error("lock flag not cleared");
  a_band_hold: assert property
    ((f0 >= FL && f0 <= FU && p0 < PL)[*3] |=> $stable(loss_of_lock_flag[0]))
    else $error("lock flag moved in band");
endmodule
bind clock_monitor clock_monitor_sva clock_monitor_sva_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .dpll_freq_err(dpll_freq_err),
  .dpll_phase_err(dpll_phase_err), .dpll_mode(dpll_mode),
  .loop_filter_word(loop_filter_word), .tuning_word(tuning_word),
  .loss_of_lock_flag(loss_of_lock_flag));
`default_nettype wire

// ---- verification/ref_source_model.sv ----
// Purpose: reference pulse sources, one per input
// Assumes: period in clocks, 0 stops the source, at least 2
// Notes: edges land mid-cycle so the monitor's synchroniser is exercised
`timescale 1ns/1ps
`default_nettype none
module ref_source_model
  (
  input wire logic clk,
  input wire logic [3:0][15:0] period,
  output logic [3:0] pulse
  );
  for (genvar i = 0; i < 4; i++)
  begin : g_src
    initial
    begin
      pulse[i] = 1'b0;
      forever
      begin
        @(posedge clk);
        if (period[i] != 16'h0)
        begin
          repeat (period[i] - 2) @(posedge clk);
          #37 pulse[i] = 1'b1;
          @(posedge clk);
          #37 pulse[i] = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire
